/* src/periph_irq_pkg.sv */
/*
 * Shared constants for the peripheral interrupt enable and flag block:
 * register offsets, bit positions, reset values and AXI4-Lite answer codes.
 * Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
 */
package periph_irq_pkg;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h04;
    localparam logic [7:0] OFS_CORE_CTRL = 8'h08;
    localparam logic [7:0] OFS_FLAG_CLEAR = 8'h0C;
    localparam int ADDR_W = 8;

    // ****************************************************************
    // Bit positions: event bits shared by enable, flag and clear registers, then core control bits
    // ****************************************************************
    localparam int BIT_ADC = 6;
    localparam int BIT_CAPCMP = 5;
    localparam int BIT_COMPARATOR = 3;
    localparam int BIT_TIMER2 = 1;
    localparam int BIT_TIMER1 = 0;
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_GROUP_EN = 6;

    // Implemented bits: full and reduced variant
    localparam logic [7:0] IMPL_FULL = 8'h6B;
    localparam logic [7:0] IMPL_REDUCED = 8'h09;
    localparam logic [7:0] CORE_CTRL_MASK = 8'hC0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] RST_CORE_CTRL = 8'h00;

    // ****************************************************************
    // Capture/compare modes and bus answers
    // ****************************************************************
    localparam logic [1:0] CCP_OFF = 2'h0;
    localparam logic [1:0] CCP_CAPTURE = 2'h1;
    localparam logic [1:0] CCP_COMPARE = 2'h2;
    localparam logic [1:0] CCP_PWM = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* src/periph_irq_flags.sv */
/*
 * Peripheral interrupt enable and request-flag logic with an AXI4-Lite slave.
 * Peripheral event inputs are synchronous to aclk; pulse inputs are high for
 * one cycle per event. The request output feeds the core's interrupt logic.
 */
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps

module periph_irq_flags
    import periph_irq_pkg::*;
#(
    parameter bit FULL_VARIANT = 1'b1,
    parameter int TIMER1_W = 16,
    parameter int TIMER2_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic adc_done_pulse,
    input wire logic [1:0] capcmp_mode,
    input wire logic capture_pulse,
    input wire logic [TIMER1_W-1:0] timer1_count,
    input wire logic [TIMER1_W-1:0] compare_value,
    input wire logic comparator_out,
    input wire logic [TIMER2_W-1:0] timer2_count,
    input wire logic [TIMER2_W-1:0] timer2_period_value,
    input wire logic timer1_overflow_pulse,
    output logic periph_irq_req
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    if (TIMER1_W < 1 || TIMER1_W > 32) begin : g_bad_timer1_width
        $error("Timer1 width must lie between 1 and 32");
    end

    if (TIMER2_W < 1 || TIMER2_W > 32) begin : g_bad_timer2_width
        $error("Timer2 width must lie between 1 and 32");
    end

    // Bit positions must agree with the implemented-bit masks
    localparam logic [7:0] EVENT_BITS = 8'((1 << BIT_ADC) | (1 << BIT_CAPCMP) | (1 << BIT_COMPARATOR)
        | (1 << BIT_TIMER2) | (1 << BIT_TIMER1));
    localparam logic [7:0] CTRL_BITS = 8'((1 << BIT_GLOBAL_EN) | (1 << BIT_GROUP_EN));

    if (EVENT_BITS != IMPL_FULL) begin : g_bad_event_map
        $error("Event bit positions disagree with the full-variant mask");
    end

    if ((IMPL_REDUCED & ~IMPL_FULL) != 8'h00) begin : g_bad_reduced
        $error("Reduced-variant mask must be a subset of the full mask");
    end

    if (CTRL_BITS != CORE_CTRL_MASK) begin : g_bad_ctrl_map
        $error("Core control bit positions disagree with its mask");
    end

    if (IMPL_FULL[7] || IMPL_FULL[4] || IMPL_FULL[2]) begin : g_bad_reserved
        $error("Bits 7, 4 and 2 must stay unimplemented");
    end

    if (RST_IRQ_ENABLE != 8'h00 || RST_IRQ_FLAGS != 8'h00) begin : g_bad_reset
        $error("Enable and flag registers must clear on reset");
    end

    if (RESP_OKAY == RESP_SLVERR) begin : g_bad_resp
        $error("Bus answer codes must differ");
    end

    if (ADDR_W < 4) begin : g_bad_addr_w
        $error("Address width too narrow for the register map");
    end

    if (OFS_IRQ_ENABLE[1:0] != 2'h0 || OFS_IRQ_FLAGS[1:0] != 2'h0 || OFS_CORE_CTRL[1:0] != 2'h0
        || OFS_FLAG_CLEAR[1:0] != 2'h0) begin : g_bad_align
        $error("Register offsets must be word aligned");
    end

    if (OFS_IRQ_ENABLE == OFS_IRQ_FLAGS || OFS_IRQ_ENABLE == OFS_CORE_CTRL
        || OFS_IRQ_ENABLE == OFS_FLAG_CLEAR || OFS_IRQ_FLAGS == OFS_CORE_CTRL
        || OFS_IRQ_FLAGS == OFS_FLAG_CLEAR || OFS_CORE_CTRL == OFS_FLAG_CLEAR) begin : g_bad_overlap
        $error("Register offsets must be distinct");
    end

    localparam logic [7:0] IMPL = FULL_VARIANT ? IMPL_FULL : IMPL_REDUCED;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        // Register contents
        logic [7:0] enable;
        logic [7:0] flags;
        logic [7:0] core_ctrl;

        // Event edge detectors
        logic comp_prev;
        logic comp_seen;
        logic t2_eq;
        logic cmp_eq;

        // Write channel
        logic have_aw;
        logic [ADDR_W-1:0] aw_addr;
        logic have_w;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;

        // Read channel
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;

        // Request output
        logic irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a == OFS_IRQ_ENABLE || a == OFS_IRQ_FLAGS || a == OFS_CORE_CTRL || a == OFS_FLAG_CLEAR;
    endfunction

    function automatic logic [7:0] read_value(input state_t s, input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            OFS_IRQ_ENABLE: v = s.enable & IMPL;
            OFS_IRQ_FLAGS: v = s.flags & IMPL;
            OFS_CORE_CTRL: v = s.core_ctrl & CORE_CTRL_MASK;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ****************************************************************
    // Address decode and edge detection
    // ****************************************************************
    function automatic logic [1:0] answer_code(input logic [ADDR_W-1:0] a);
        return is_mapped(a) ? RESP_OKAY : RESP_SLVERR;
    endfunction

    function automatic logic rising(input logic now, input logic prev);
        return now && !prev;
    endfunction

    // ****************************************************************
    // Event decode
    // ****************************************************************
    function automatic logic capcmp_event(input logic [1:0] mode, input logic capture, input logic match_rise);
        logic hit;
        hit = 1'b0;
        case (mode)
            CCP_CAPTURE: hit = capture;
            CCP_COMPARE: hit = match_rise;
            CCP_PWM: hit = 1'b0;
            CCP_OFF: hit = 1'b0;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [7:0] event_vector(input logic adc, input logic capcmp, input logic comp_change,
        input logic t2_match, input logic t1_ovf);
        logic [7:0] v;
        v = 8'h00;
        v[BIT_ADC] = adc;
        v[BIT_CAPCMP] = capcmp;
        v[BIT_COMPARATOR] = comp_change;
        v[BIT_TIMER2] = t2_match;
        v[BIT_TIMER1] = t1_ovf;
        return v & IMPL;
    endfunction

    // ****************************************************************
    // Register write
    // ****************************************************************
    function automatic state_t apply_write(input state_t s, input logic [7:0] old_flags,
        input logic [ADDR_W-1:0] a, input logic [7:0] d);
        state_t r;
        r = s;
        case (a)
            OFS_IRQ_ENABLE: r.enable = d & IMPL;
            OFS_IRQ_FLAGS: r.flags = d & IMPL;
            OFS_FLAG_CLEAR: r.flags = old_flags & ~d & IMPL;
            OFS_CORE_CTRL: r.core_ctrl = d & CORE_CTRL_MASK;
            default: r = s;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [7:0] ev;
        logic t2_eq_now;
        logic cmp_eq_now;
        logic aw_take;
        logic w_take;
        logic [7:0] pend;
        ev = 8'h00;
        t2_eq_now = timer2_count == timer2_period_value;
        cmp_eq_now = timer1_count == compare_value;
        aw_take = s_axi_awvalid && s_q.awready;
        w_take = s_axi_wvalid && s_q.wready;
        pend = 8'h00;
        s_d = s_q;

        // ****************************************************************
        // Peripheral events, independent of any enable
        // ****************************************************************
        ev = event_vector(adc_done_pulse,
            capcmp_event(capcmp_mode, capture_pulse, rising(cmp_eq_now, s_q.cmp_eq)),
            s_q.comp_seen && (comparator_out != s_q.comp_prev),
            rising(t2_eq_now, s_q.t2_eq),
            timer1_overflow_pulse);
        s_d.comp_prev = comparator_out;
        s_d.comp_seen = 1'b1;
        s_d.t2_eq = t2_eq_now;
        s_d.cmp_eq = cmp_eq_now;

        // ****************************************************************
        // Write channel: address and data in either order
        // ****************************************************************
        if (aw_take) begin
            s_d.have_aw = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end

        if (w_take) begin
            s_d.have_w = 1'b1;
            s_d.w_data = s_axi_wdata[7:0];
            s_d.w_lane0 = s_axi_wstrb[0];
        end

        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        if (s_d.have_aw && s_d.have_w && !s_q.bvalid) begin
            s_d.have_aw = 1'b0;
            s_d.have_w = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = answer_code(s_d.aw_addr);
            if (s_d.w_lane0) begin
                s_d = apply_write(s_d, s_q.flags, s_d.aw_addr, s_d.w_data);
            end
        end

        // Flags only fall on a software write; a new event wins over a clear
        s_d.flags = s_d.flags | ev;
        s_d.awready = !s_d.have_aw && !s_d.bvalid;
        s_d.wready = !s_d.have_w && !s_d.bvalid;

        // ****************************************************************
        // Read channel
        // ****************************************************************
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = {24'h000000, read_value(s_q, s_axi_araddr)};
            s_d.rresp = answer_code(s_axi_araddr);
        end
        s_d.arready = !s_d.rvalid;

        // ****************************************************************
        // Combined request to the core
        // ****************************************************************
        pend = s_d.flags & s_d.enable & IMPL;
        s_d.irq = (|pend) && s_d.core_ctrl[BIT_GROUP_EN]
            && s_d.core_ctrl[BIT_GLOBAL_EN];
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.enable <= RST_IRQ_ENABLE;
            s_q.flags <= RST_IRQ_FLAGS;
            s_q.core_ctrl <= RST_CORE_CTRL;
            s_q.bresp <= RESP_OKAY;
            s_q.rresp <= RESP_OKAY;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Output ports, straight from the state register
    // ****************************************************************
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign periph_irq_req = s_q.irq;

endmodule

/* tb/periph_irq_assertions.sv */
/* Checker on the ports of periph_irq_flags.
   Assumes one clock aclk and the active-low reset aresetn. */
`timescale 1ns/100ps
module periph_irq_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic periph_irq_req
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("bad write answer code");
    a_irq_sticky: assert property ($fell(periph_irq_req) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("request fell without a write");
    a_reset_quiet: assert property ($rose(aresetn) |-> !periph_irq_req)
        else $error("request high after reset");
    c_irq_rise: cover property ($rose(periph_irq_req));
    c_irq_fall: cover property ($fell(periph_irq_req));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind periph_irq_flags periph_irq_checker periph_irq_checker_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .periph_irq_req);

/* tb/periph_event_model.sv */
/* Model of the peripherals that feed the block.
   Assumes the bench raises one fire bit for one cycle per event. */
`timescale 1ns/100ps
module periph_event_model (
    input wire logic aclk,
    input wire logic [4:0] fire,
    output logic adc_done_pulse,
    output logic capture_pulse,
    output logic timer1_overflow_pulse,
    output logic comparator_out,
    output logic [15:0] timer1_count,
    output logic [15:0] compare_value,
    output logic [7:0] timer2_count,
    output logic [7:0] timer2_period_value
);
    // ****
    // Event sources
    // ****
    assign adc_done_pulse = fire[0];
    assign capture_pulse = fire[1];
    assign compare_value = 16'hA5C3;
    assign timer1_count = fire[1] ? compare_value : ~compare_value;
    assign timer1_overflow_pulse = fire[2];
    assign timer2_period_value = 8'h3C;
    assign timer2_count = fire[4] ? timer2_period_value : ~timer2_period_value;
    initial comparator_out = 1'b0;
    always @(posedge aclk) if (fire[3]) comparator_out <= ~comparator_out;
endmodule

/* tb/test_peripheral_irq_enable_flags.sv */
/* Self-checking bench for periph_irq_flags against an integer model.
   Assumes periph_event_model and the checker are compiled first. */
`timescale 1ns/100ps
module test_peripheral_irq_enable_flags;
    import periph_irq_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, periph_irq_req, adc_done_pulse, capture_pulse;
    logic comparator_out, timer1_overflow_pulse;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, timer2_count, timer2_period_value;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] capcmp_mode = 2'h0, s_axi_bresp, s_axi_rresp, rr;
    logic [4:0] fire = '0;
    logic [15:0] timer1_count, compare_value;
    int mismatches = 0, tests_run = 0, en = 0, fl = 0, ct = 0, x = 0;
    always #50 aclk = ~aclk;
    periph_irq_flags periph_irq_flags_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .adc_done_pulse, .capcmp_mode, .capture_pulse, .timer1_count, .compare_value, .comparator_out,
        .timer2_count, .timer2_period_value, .timer1_overflow_pulse, .periph_irq_req);
    periph_event_model periph_event_model_i (.aclk, .fire, .adc_done_pulse, .capture_pulse, .timer1_overflow_pulse,
        .comparator_out, .timer1_count, .compare_value, .timer2_count, .timer2_period_value);
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta = 1'b0, tw = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ta = ta || s_axi_awready;
            tw = tw || s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        do @(negedge aclk); while (!s_axi_bvalid);
        rr = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic ev(input logic [4:0] f);
        @(posedge aclk);
        fire <= f;
        @(posedge aclk);
        fire <= '0;
        fl |= {1'b0, f[0], f[1] && capcmp_mode inside {CCP_CAPTURE, CCP_COMPARE}, 1'b0, f[3], 1'b0, f[4], f[2]};
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        rv = $urandom(31022);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            rd(a[7:0]);
            chk(rv, 32'h0);
        end
        rd(8'h10);
        chk({rv[31:2], rr}, {30'h0, RESP_SLVERR});
        wr(8'h10, 32'hFF);
        chk(rr, RESP_SLVERR);
        for (int a = 0; a < 8; a += 4) begin
            wr(a[7:0], 32'hFF);
            rd(a[7:0]);
            chk(rv, IMPL_FULL);
            wr(a[7:0], 32'h0);
        end
        for (int m = 0; m < 5; m++) begin
            capcmp_mode <= m[1:0];
            ev(5'h1F);
            repeat (20) @(posedge aclk);
            rd(OFS_IRQ_FLAGS);
            chk(rv, fl);
            wr(OFS_FLAG_CLEAR, 32'hFF);
            fl = 0;
        end
        for (int i = 0; i < 24; i++) begin
            ev(5'($urandom));
            x = $urandom & 32'h6B;
            wr(OFS_FLAG_CLEAR, x);
            fl &= ~x;
            en = $urandom & 32'hFF;
            wr(OFS_IRQ_ENABLE, en);
            en &= IMPL_FULL;
            ct = {i[1:0], 6'h0};
            wr(OFS_CORE_CTRL, ct);
            repeat (2) @(negedge aclk);
            chk(periph_irq_req, ((fl & en) != 0) && ct[7] && ct[6]);
            rd(OFS_IRQ_FLAGS);
            chk(rv, fl);
        end
        complete_run;
    end
    initial begin
        #3000000;
        mismatches++;
        complete_run;
    end
endmodule
